//--- logic/dvp_pkg.sv
package dvp_pkg;
	// register bus
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_MISC = 8'h00;
	localparam logic [7:0] ADDR_POL = 8'h04;
	localparam logic [7:0] ADDR_CODING = 8'h08;
	localparam logic [7:0] ADDR_LINE = 8'h0C;
	localparam logic [7:0] ADDR_VTIM = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// field positions
	localparam int MISC_SD_BIT = 1;
	localparam int MISC_CM_BIT = 2;
	localparam int POL_VS = 0;
	localparam int POL_HS = 1;
	localparam int POL_DE = 2;
	localparam int POL_SD = 3;
	localparam int POL_CM = 4;
	localparam int POL_W = 5;
	localparam int LOOSE_BIT = 3;
	localparam int ACTIVE_VIDEO_REGION_LSB = 0;
	localparam int ACTIVE_VIDEO_REGION_W = 11;
	localparam int VBP_LSB = 16;
	localparam int VFP_LSB = 24;
	localparam int PORCH_W = 6;
	localparam int ST_ARMED = 0;
	localparam int ST_ACTIVE = 1;
	localparam int ST_SD_PEND = 2;
	localparam int ST_CM_PEND = 3;
	localparam int ST_OVF = 4;
	localparam int ST_LINE_LSB = 16;
	localparam int LINE_CNT_W = 12;
	localparam int PIX_BUS_W = 24;
	// reset values
	localparam logic [POL_W-1:0] RST_POL = 5'h00;
	localparam logic [2:0] RST_CODING = 3'h5;
	localparam logic [ACTIVE_VIDEO_REGION_W-1:0] RST_ACTIVE_VIDEO_REGION = 11'h1E0;
	localparam logic [PORCH_W-1:0] RST_VBP = 6'h00;
	localparam logic [PORCH_W-1:0] RST_VFP = 6'h00;
	localparam logic [LINE_CNT_W-1:0] LINE_MAX = 12'hFFF;

	typedef enum logic [2:0] {
		CODE_16C1 = 3'h0,
		CODE_16C2 = 3'h1,
		CODE_16C3 = 3'h2,
		CODE_18C1 = 3'h3,
		CODE_18C2 = 3'h4,
		CODE_24 = 3'h5
	} dvp_coding_e;

	typedef enum logic [0:0] {
		CAP_WAIT = 1'h0,
		CAP_RUN = 1'h1
	} dvp_cap_e;

	typedef enum logic [1:0] {
		KIND_SYNC = 2'h0,
		KIND_SHUTDOWN = 2'h1,
		KIND_COLOR = 2'h2
	} dvp_kind_e;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} dvp_pixel_s;

	typedef struct packed {
		dvp_kind_e kind;
		logic value;
		logic vsync;
		logic hsync;
		logic de;
	} dvp_ctrl_s;

	typedef struct packed {
		logic pclk;
		logic vsync;
		logic hsync;
		logic de;
		logic shutdn;
		logic colorm;
		logic [PIX_BUS_W-1:0] data;
	} dvp_pins_s;
endpackage : dvp_pkg

//--- logic/dvp_buf2.sv
`timescale 1ns/1ns
module dvp_buf2 #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	if (WIDTH < 1) begin : g_bad_width
		$error("WIDTH must be positive");
	end

	logic [1:0] cnt;
	logic [WIDTH-1:0] spare;
	logic push;
	logic pop;

	assign in_ready = (cnt != 2'h2);
	assign out_valid = (cnt != 2'h0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 2'h0;
		end else if (push && !pop) begin
			cnt <= cnt + 2'h1;
		end else if (pop && !push) begin
			cnt <= cnt - 2'h1;
		end
	end

	// head entry is the registered output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_data <= '0;
			spare <= '0;
		end else begin
			if (pop) begin
				out_data <= (cnt == 2'h2) ? spare : in_data;
			end else if (push && cnt == 2'h0) begin
				out_data <= in_data;
			end
			if (push && ((cnt == 2'h1 && !pop) || cnt == 2'h2)) begin
				spare <= in_data;
			end
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_first_word;
		push && cnt == 2'h0 |=> out_valid && out_data == $past(in_data);
	endproperty
	a_first_word: assert property (p_first_word) else $error("word lost");

	property p_full_stalls;
		cnt == 2'h2 && !pop |=> cnt == 2'h2 && !in_ready;
	endproperty
	a_full_stalls: assert property (p_full_stalls) else $error("full");
endmodule : dvp_buf2

//--- logic/dvp_pixel_input.sv
`timescale 1ns/1ns
// Functional notes
// - accept a 24-line parallel pixel bus carrying live video
// - control changes and pixels go into two separate buffers
// - writing misc config bits 2:1 raises shutdown and colour mode commands
// - 24-bit coding: red 23..16, green 15..8, blue 7..0
// - three 16-bit layouts, unused lines ignored
// - two 18-bit layouts, unused lines ignored
// - each control input has a programmable active level
// - after reset ignore everything until first frame sync edge
// - packed 18-bit coding forces low two line-length bits to zero
// - vertical timing covers up to 2047 active lines
// - vertical timing covers up to 63 back and front porch lines
// - commands wait while the active video region is in progress
module dvp_pixel_input #(
	parameter int PPL_W = 14
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic [dvp_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [dvp_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pixel pins
	input wire logic dpi_pclk,
	input wire logic dpi_vsync,
	input wire logic dpi_hsync,
	input wire logic dpi_de,
	input wire logic dpi_shutdn,
	input wire logic dpi_colorm,
	input wire logic [dvp_pkg::PIX_BUS_W-1:0] dpi_data,
	output logic dpi_halt,
	// control stream
	output logic ctrl_valid,
	input wire logic ctrl_ready,
	output dvp_pkg::dvp_ctrl_s ctrl_data,
	// pixel stream
	output logic pix_valid,
	input wire logic pix_ready,
	output dvp_pkg::dvp_pixel_s pix_data,
	// timing toward the packet builder
	output logic [PPL_W-1:0] ppl_eff,
	output logic [dvp_pkg::ACTIVE_VIDEO_REGION_W-1:0] active_video_region,
	output logic [dvp_pkg::PORCH_W-1:0] vbp,
	output logic [dvp_pkg::PORCH_W-1:0] vfp,
	output logic in_active
);
	if (PPL_W < 3 || PPL_W > 16) begin : g_bad_ppl
		$error("PPL_W out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// registers and bus state
	logic misc_sd;
	logic misc_cm;
	logic [dvp_pkg::POL_W-1:0] pol;
	logic [2:0] coding;
	logic loose;
	logic [PPL_W-1:0] ppl;
	logic ovf;
	logic aw_hold;
	logic w_hold;
	logic [dvp_pkg::ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic ar_fire;
	logic [32:0] wr_old;
	logic [32:0] rd_sel;
	logic [31:0] wr_new;
	logic wr_misc;
	logic wr_sd_bit;
	logic wr_cm_bit;
	logic code18_packed;
	logic [PPL_W-1:0] ppl_c;
	dvp_pkg::dvp_cap_e state;
	logic [dvp_pkg::LINE_CNT_W-1:0] line;
	logic sd_pend;
	logic cm_pend;
	logic sd_val;
	logic cm_val;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction : merge

	// top bit flags an unmapped address
	function automatic logic [32:0] reg_word(
		input logic [dvp_pkg::ADDR_W-1:0] a);
		logic [31:0] w;
		logic err;
		w = 32'h0000_0000;
		err = 1'b0;
		case ({a[dvp_pkg::ADDR_W-1:2], 2'h0})
			dvp_pkg::ADDR_MISC: begin
				w[dvp_pkg::MISC_SD_BIT] = misc_sd;
				w[dvp_pkg::MISC_CM_BIT] = misc_cm;
			end
			dvp_pkg::ADDR_POL: w[dvp_pkg::POL_W-1:0] = pol;
			dvp_pkg::ADDR_CODING: begin
				w[2:0] = coding;
				w[dvp_pkg::LOOSE_BIT] = loose;
			end
			dvp_pkg::ADDR_LINE: w[PPL_W-1:0] = ppl_c;
			dvp_pkg::ADDR_VTIM: begin
				w[dvp_pkg::ACTIVE_VIDEO_REGION_LSB +: dvp_pkg::ACTIVE_VIDEO_REGION_W] = active_video_region;
				w[dvp_pkg::VBP_LSB +: dvp_pkg::PORCH_W] = vbp;
				w[dvp_pkg::VFP_LSB +: dvp_pkg::PORCH_W] = vfp;
			end
			dvp_pkg::ADDR_STATUS: begin
				w[dvp_pkg::ST_ARMED] = (state == dvp_pkg::CAP_RUN);
				w[dvp_pkg::ST_ACTIVE] = in_active;
				w[dvp_pkg::ST_SD_PEND] = sd_pend;
				w[dvp_pkg::ST_CM_PEND] = cm_pend;
				w[dvp_pkg::ST_OVF] = ovf;
				w[dvp_pkg::ST_LINE_LSB +: dvp_pkg::LINE_CNT_W] = line;
			end
			default: err = 1'b1;
		endcase
		return {err, w};
	endfunction : reg_word

	assign s_axi_awready = !aw_hold;
	assign s_axi_wready = !w_hold;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_hold & w_hold & !s_axi_bvalid;
	assign ar_fire = s_axi_arvalid & s_axi_arready;
	// a process also follows the registers that the function reads
	always_comb begin
		wr_old = reg_word(aw_addr);
		rd_sel = reg_word(s_axi_araddr);
	end
	assign wr_new = merge(wr_old[31:0], w_data, w_strb);
	assign wr_misc = wr_fire && ({aw_addr[dvp_pkg::ADDR_W-1:2], 2'h0}
		== dvp_pkg::ADDR_MISC) && w_strb[0];
	assign wr_sd_bit = wr_new[dvp_pkg::MISC_SD_BIT];
	assign wr_cm_bit = wr_new[dvp_pkg::MISC_CM_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dvp_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_hold <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_hold <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_old[32] ? dvp_pkg::RESP_SLVERR
					: dvp_pkg::RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= dvp_pkg::RESP_OKAY;
		end else if (ar_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_sel[31:0];
			s_axi_rresp <= rd_sel[32] ? dvp_pkg::RESP_SLVERR
				: dvp_pkg::RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// configuration writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			misc_sd <= 1'b0;
			misc_cm <= 1'b0;
			pol <= dvp_pkg::RST_POL;
			coding <= dvp_pkg::RST_CODING;
			loose <= 1'b0;
			ppl <= '0;
			active_video_region <= dvp_pkg::RST_ACTIVE_VIDEO_REGION;
			vbp <= dvp_pkg::RST_VBP;
			vfp <= dvp_pkg::RST_VFP;
		end else if (wr_fire) begin
			case ({aw_addr[dvp_pkg::ADDR_W-1:2], 2'h0})
				dvp_pkg::ADDR_MISC: begin
					misc_sd <= wr_sd_bit;
					misc_cm <= wr_cm_bit;
				end
				dvp_pkg::ADDR_POL: pol <= wr_new[dvp_pkg::POL_W-1:0];
				dvp_pkg::ADDR_CODING: begin
					coding <= wr_new[2:0];
					loose <= wr_new[dvp_pkg::LOOSE_BIT];
				end
				dvp_pkg::ADDR_LINE: ppl <= wr_new[PPL_W-1:0];
				dvp_pkg::ADDR_VTIM: begin
					active_video_region <= wr_new[dvp_pkg::ACTIVE_VIDEO_REGION_LSB +: dvp_pkg::ACTIVE_VIDEO_REGION_W];
					vbp <= wr_new[dvp_pkg::VBP_LSB +: dvp_pkg::PORCH_W];
					vfp <= wr_new[dvp_pkg::VFP_LSB +: dvp_pkg::PORCH_W];
				end
				default: begin
				end
			endcase
		end
	end

	assign code18_packed = !loose && (coding == dvp_pkg::CODE_18C1
		|| coding == dvp_pkg::CODE_18C2);

	always_comb begin
		ppl_c = ppl;
		if (code18_packed) begin
			ppl_c[1:0] = 2'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ppl_eff <= '0;
		end else begin
			ppl_eff <= ppl_c;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser and pixel clock edge
	dvp_pkg::dvp_pins_s pin_now;
	dvp_pkg::dvp_pins_s s1;
	dvp_pkg::dvp_pins_s s2;
	dvp_pkg::dvp_pins_s s3;
	logic pclk_level;
	logic pix_edge;
	logic cur_vs;
	logic cur_hs;
	logic cur_de;
	logic cur_sd;
	logic cur_cm;
	logic prev_vs;
	logic prev_hs;
	logic prev_de;
	logic prev_sd;
	logic prev_cm;

	assign pin_now = {dpi_pclk, dpi_vsync, dpi_hsync, dpi_de, dpi_shutdn,
		dpi_colorm, dpi_data};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			pclk_level <= 1'b0;
		end else begin
			s1 <= pin_now;
			s2 <= s1;
			s3 <= s2;
			if (s2.pclk == s3.pclk) begin
				pclk_level <= s3.pclk;
			end
		end
	end

	assign pix_edge = s2.pclk & s3.pclk & !pclk_level;
	assign cur_vs = s3.vsync ^ pol[dvp_pkg::POL_VS];
	assign cur_hs = s3.hsync ^ pol[dvp_pkg::POL_HS];
	assign cur_de = s3.de ^ pol[dvp_pkg::POL_DE];
	assign cur_sd = s3.shutdn ^ pol[dvp_pkg::POL_SD];
	assign cur_cm = s3.colorm ^ pol[dvp_pkg::POL_CM];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_vs <= 1'b0;
			prev_hs <= 1'b0;
			prev_de <= 1'b0;
			prev_sd <= 1'b0;
			prev_cm <= 1'b0;
		end else if (pix_edge) begin
			prev_vs <= cur_vs;
			prev_hs <= cur_hs;
			prev_de <= cur_de;
			prev_sd <= cur_sd;
			prev_cm <= cur_cm;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame arming, line count and capture
	logic vs_rise;
	logic hs_rise;
	logic run_edge;
	logic sync_chg;
	logic sync_push;
	logic pix_want;
	logic ctrl_rdy;
	logic pix_rdy;
	logic ctrl_push;
	logic pix_push;
	logic ovf_set;
	logic cmd_ok;
	logic sd_emit;
	logic cm_emit;
	logic [dvp_pkg::LINE_CNT_W-1:0] act_lo;
	logic [dvp_pkg::LINE_CNT_W-1:0] act_hi;
	dvp_pkg::dvp_ctrl_s ctrl_in;
	dvp_pkg::dvp_pixel_s pix_in;

	assign vs_rise = pix_edge & cur_vs & !prev_vs;
	assign hs_rise = pix_edge & cur_hs & !prev_hs;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= dvp_pkg::CAP_WAIT;
		end else begin
			case (state)
				dvp_pkg::CAP_WAIT: if (vs_rise) state <= dvp_pkg::CAP_RUN;
				dvp_pkg::CAP_RUN: state <= dvp_pkg::CAP_RUN;
				default: state <= dvp_pkg::CAP_WAIT;
			endcase
		end
	end

	// the arming edge itself opens the frame
	assign run_edge = pix_edge & ((state == dvp_pkg::CAP_RUN) | vs_rise);
	assign sync_chg = run_edge & ({cur_vs, cur_hs, cur_de}
		!= {prev_vs, prev_hs, prev_de});
	assign pix_want = run_edge & cur_de;
	assign sync_push = sync_chg & ctrl_rdy;
	assign pix_push = pix_want & pix_rdy;
	assign ovf_set = (sync_chg & !ctrl_rdy) | (pix_want & !pix_rdy);
	assign dpi_halt = !(ctrl_rdy & pix_rdy);

	assign act_lo = dvp_pkg::LINE_CNT_W'(vbp);
	assign act_hi = act_lo + dvp_pkg::LINE_CNT_W'(active_video_region);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line <= '0;
			in_active <= 1'b0;
		end else begin
			if (vs_rise) begin
				line <= '0;
			end else if (state == dvp_pkg::CAP_RUN && hs_rise
				&& line != dvp_pkg::LINE_MAX) begin
				line <= line + 12'h001;
			end
			in_active <= (state == dvp_pkg::CAP_RUN) && (line >= act_lo)
				&& (line < act_hi);
		end
	end

	// commands leave only outside the active region of an armed frame
	assign cmd_ok = (state == dvp_pkg::CAP_RUN) & !in_active & ctrl_rdy
		& !sync_chg;
	assign sd_emit = cmd_ok & sd_pend;
	assign cm_emit = cmd_ok & cm_pend & !sd_pend;
	assign ctrl_push = sync_push | sd_emit | cm_emit;

	// a new trigger wins over the emit that clears it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sd_pend <= 1'b0;
			sd_val <= 1'b0;
			cm_pend <= 1'b0;
			cm_val <= 1'b0;
			ovf <= 1'b0;
		end else begin
			if (wr_misc || (run_edge && cur_sd != prev_sd)) begin
				sd_pend <= 1'b1;
				sd_val <= wr_misc ? wr_sd_bit : cur_sd;
			end else if (sd_emit) begin
				sd_pend <= 1'b0;
			end
			if (wr_misc || (run_edge && cur_cm != prev_cm)) begin
				cm_pend <= 1'b1;
				cm_val <= wr_misc ? wr_cm_bit : cur_cm;
			end else if (cm_emit) begin
				cm_pend <= 1'b0;
			end
			if (ovf_set) begin
				ovf <= 1'b1;
			end else if (wr_fire && w_strb[0] && w_data[dvp_pkg::ST_OVF]
				&& {aw_addr[dvp_pkg::ADDR_W-1:2], 2'h0}
				== dvp_pkg::ADDR_STATUS) begin
				ovf <= 1'b0;
			end
		end
	end

	always_comb begin
		ctrl_in = '{kind: dvp_pkg::KIND_SYNC, value: 1'b0, vsync: prev_vs,
			hsync: prev_hs, de: prev_de};
		if (sync_chg) begin
			ctrl_in.vsync = cur_vs;
			ctrl_in.hsync = cur_hs;
			ctrl_in.de = cur_de;
		end else if (sd_emit) begin
			ctrl_in.kind = dvp_pkg::KIND_SHUTDOWN;
			ctrl_in.value = sd_val;
		end else if (cm_emit) begin
			ctrl_in.kind = dvp_pkg::KIND_COLOR;
			ctrl_in.value = cm_val;
		end
	end

	// colour unpacking, narrow fields sit in the low bits
	always_comb begin
		pix_in = '0;
		case (dvp_pkg::dvp_coding_e'(coding))
			dvp_pkg::CODE_16C1: begin
				pix_in.red[4:0] = s3.data[15:11];
				pix_in.green[5:0] = s3.data[10:5];
				pix_in.blue[4:0] = s3.data[4:0];
			end
			dvp_pkg::CODE_16C2: begin
				pix_in.red[4:0] = s3.data[20:16];
				pix_in.green[5:0] = s3.data[13:8];
				pix_in.blue[4:0] = s3.data[4:0];
			end
			dvp_pkg::CODE_16C3: begin
				pix_in.red[4:0] = s3.data[21:17];
				pix_in.green[5:0] = s3.data[13:8];
				pix_in.blue[4:0] = s3.data[5:1];
			end
			dvp_pkg::CODE_18C1: begin
				pix_in.red[5:0] = s3.data[17:12];
				pix_in.green[5:0] = s3.data[11:6];
				pix_in.blue[5:0] = s3.data[5:0];
			end
			dvp_pkg::CODE_18C2: begin
				pix_in.red[5:0] = s3.data[21:16];
				pix_in.green[5:0] = s3.data[13:8];
				pix_in.blue[5:0] = s3.data[5:0];
			end
			default: begin
				pix_in.red = s3.data[23:16];
				pix_in.green = s3.data[15:8];
				pix_in.blue = s3.data[7:0];
			end
		endcase
	end

	dvp_buf2 #(.WIDTH($bits(dvp_pkg::dvp_ctrl_s))) u_ctrl_buf (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(ctrl_push),
		.in_ready(ctrl_rdy),
		.in_data(ctrl_in),
		.out_valid(ctrl_valid),
		.out_ready(ctrl_ready),
		.out_data(ctrl_data)
	);

	dvp_buf2 #(.WIDTH($bits(dvp_pkg::dvp_pixel_s))) u_pix_buf (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(pix_push),
		.in_ready(pix_rdy),
		.in_data(pix_in),
		.out_valid(pix_valid),
		.out_ready(pix_ready),
		.out_data(pix_data)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_arm;
		state == dvp_pkg::CAP_WAIT ##1 state == dvp_pkg::CAP_RUN;
	endsequence
	property p_arm;
		s_arm |-> $past(vs_rise);
	endproperty
	a_arm: assert property (p_arm) else $error("armed without sync");

	property p_wait_quiet;
		state == dvp_pkg::CAP_WAIT && !vs_rise |-> !ctrl_push && !pix_push;
	endproperty
	a_wait_quiet: assert property (p_wait_quiet) else $error("early push");

	property p_pix_de;
		pix_push |-> cur_de && pix_edge;
	endproperty
	a_pix_de: assert property (p_pix_de) else $error("pixel without de");

	property p_cmd_hold;
		sd_emit || cm_emit |-> !in_active && ctrl_in.kind != dvp_pkg::KIND_SYNC;
	endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("cmd in active");

	property p_misc_trig;
		wr_misc |=> sd_pend && cm_pend && sd_val == $past(wr_sd_bit);
	endproperty
	a_misc_trig: assert property (p_misc_trig) else $error("no cmd");

	property p_ppl;
		code18_packed |=> ppl_eff[1:0] == 2'h0;
	endproperty
	a_ppl: assert property (p_ppl) else $error("line length lsbs");

	property p_ovf;
		pix_want && !pix_rdy |-> dpi_halt ##1 ovf;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow missed");

	property p_unpack24;
		pix_push && coding == dvp_pkg::CODE_24 |-> pix_in.red
			== s3.data[23:16] && pix_in.blue == s3.data[7:0];
	endproperty
	a_unpack24: assert property (p_unpack24) else $error("24-bit map");

	property p_line_reset;
		vs_rise |=> line == 12'h000;
	endproperty
	a_line_reset: assert property (p_line_reset) else $error("line count");

	property p_bresp;
		wr_fire |=> s_axi_bvalid ##0 (s_axi_bresp == dvp_pkg::RESP_SLVERR)
			== $past(wr_old[32]);
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response");
endmodule : dvp_pixel_input

//--- sim/dvp_host_model.sv
`timescale 1ns/1ns
module dvp_host_model (
	// pixel pins
	output logic pclk,
	output logic vs,
	output logic hs,
	output logic de,
	output logic sd,
	output logic cm,
	output logic [23:0] d,
	// stall from the block
	input wire logic halt
);
	initial begin
		pclk = 1'b0;
		vs = 1'b0;
		hs = 1'b0;
		de = 1'b0;
		sd = 1'b0;
		cm = 1'b0;
		d = 24'h000000;
	end

	////////////////////////////////////////////////////////////////
	// one pixel clock period; the clock stands still between calls
	task automatic beat(input logic v, h, e, input logic [23:0] x);
		while (halt === 1'b1) #10;
		#3;
		vs = v;
		hs = h;
		de = e;
		d = x;
		#80 pclk = 1'b1;
		#80 pclk = 1'b0;
	endtask : beat

	// command pins change between pixel clock periods
	task automatic cmd_pins(input logic s, c);
		sd = s;
		cm = c;
	endtask : cmd_pins
endmodule : dvp_host_model

//--- sim/dvp_pixel_input_tb_top.sv
`timescale 1ns/1ns
module dvp_pixel_input_tb_top;
	localparam logic [23:0] P = 24'hA5C3E9;
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic dpi_pclk, dpi_vsync, dpi_hsync, dpi_de, dpi_shutdn;
	logic dpi_colorm, dpi_halt, in_active;
	logic [23:0] dpi_data;
	logic ctrl_valid, ctrl_ready, pix_valid, pix_ready;
	dvp_pkg::dvp_ctrl_s ctrl_data;
	dvp_pkg::dvp_pixel_s pix_data;
	logic [13:0] ppl_eff;
	logic [10:0] active_video_region;
	logic [5:0] vbp, vfp;
	logic [23:0] pixq[$];
	dvp_pkg::dvp_ctrl_s ctlq[$];
	int miscompares, check_count, cyc;

	dvp_pixel_input dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dpi_pclk, .dpi_vsync,
		.dpi_hsync, .dpi_de, .dpi_shutdn, .dpi_colorm, .dpi_data,
		.dpi_halt, .ctrl_valid, .ctrl_ready, .ctrl_data, .pix_valid,
		.pix_ready, .pix_data, .ppl_eff, .active_video_region, .vbp, .vfp, .in_active);
	dvp_host_model host (.pclk(dpi_pclk), .vs(dpi_vsync), .hs(dpi_hsync),
		.de(dpi_de), .sd(dpi_shutdn), .cm(dpi_colorm), .d(dpi_data),
		.halt(dpi_halt));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			test_done();
		end
		if (pix_valid === 1'b1 && pix_ready === 1'b1) pixq.push_back(pix_data);
		if (ctrl_valid === 1'b1 && ctrl_ready === 1'b1)
			ctlq.push_back(ctrl_data);
	end

	task automatic chk(input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= x;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] x,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		x = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, m);
		logic [31:0] x;
		logic [1:0] r;
		rd(a, x, r);
		chk(x & m, e);
	endtask : rdchk

	task automatic pw();
		repeat (40) if (pixq.size() == 0) @(posedge aclk);
	endtask : pw

	task automatic popchk(input logic [23:0] e);
		if (pixq.size() == 0)
			chk(32'h0, 32'h1);
		else
			chk({8'h00, pixq.pop_front()}, {8'h00, e});
	endtask : popchk

	function automatic logic [23:0] map(input int c, input logic [23:0] x);
		case (c)
			0: map = {3'h0, x[15:11], 2'h0, x[10:5], 3'h0, x[4:0]};
			1: map = {3'h0, x[20:16], 2'h0, x[13:8], 3'h0, x[4:0]};
			2: map = {3'h0, x[21:17], 2'h0, x[13:8], 3'h0, x[5:1]};
			3: map = {2'h0, x[17:12], 2'h0, x[11:6], 2'h0, x[5:0]};
			4: map = {2'h0, x[21:16], 2'h0, x[13:8], 2'h0, x[5:0]};
			default: map = x;
		endcase
	endfunction : map

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] x;
		logic [1:0] r;
		{aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, cyc} = '0;
		s_axi_wstrb = 4'hF;
		ctrl_ready = 1'b1;
		pix_ready = 1'b1;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rdchk(dvp_pkg::ADDR_CODING, 32'h5, 32'h7);
		wr(dvp_pkg::ADDR_VTIM, 32'h3F3F07FF);
		rdchk(dvp_pkg::ADDR_VTIM, 32'h3F3F07FF, 32'h3F3F07FF);
		chk({2'h0, vfp, 2'h0, vbp, 5'h0, active_video_region}, 32'h3F3F07FF);
		rd(8'h18, x, r);
		chk({30'h0, r}, {30'h0, dvp_pkg::RESP_SLVERR});
		// keep line zero outside the active region
		wr(dvp_pkg::ADDR_VTIM, 32'h00020001);
		$display("test registers done");
		host.beat(1'b0, 1'b0, 1'b1, P);
		pw();
		chk(32'(pixq.size()), 32'h0);
		host.beat(1'b1, 1'b0, 1'b0, ~P);
		rdchk(dvp_pkg::ADDR_STATUS, 32'h1, 32'h1);
		$display("test arming done");
		for (int c = 0; c < 6; c++) begin
			wr(dvp_pkg::ADDR_CODING, 32'(c));
			host.beat(1'b1, 1'b0, 1'b1, P);
			pw();
			popchk(map(c, P));
		end
		$display("test codings done");
		wr(dvp_pkg::ADDR_POL, 32'h4);
		host.beat(1'b1, 1'b0, 1'b0, ~P);
		pw();
		popchk(~P);
		host.beat(1'b1, 1'b0, 1'b1, P);
		repeat (20) @(posedge aclk);
		chk(32'(pixq.size()), 32'h0);
		wr(dvp_pkg::ADDR_POL, 32'h0);
		$display("test polarity done");
		@(posedge aclk);
		pix_ready <= 1'b0;
		host.beat(1'b1, 1'b0, 1'b1, 24'h111111);
		host.beat(1'b1, 1'b0, 1'b1, 24'h222222);
		repeat (10) @(posedge aclk);
		chk({31'h0, dpi_halt}, 32'h1);
		pix_ready <= 1'b1;
		pw();
		popchk(24'h111111);
		pw();
		popchk(24'h222222);
		$display("test stall done");
		wr(dvp_pkg::ADDR_CODING, 32'h3);
		wr(dvp_pkg::ADDR_LINE, 32'h0D);
		rdchk(dvp_pkg::ADDR_LINE, 32'h0C, 32'h3FFF);
		chk({18'h0, ppl_eff}, 32'h0C);
		wr(dvp_pkg::ADDR_CODING, 32'hB);
		rdchk(dvp_pkg::ADDR_LINE, 32'h0D, 32'h3FFF);
		wr(dvp_pkg::ADDR_LINE, 32'h10);
		wr(dvp_pkg::ADDR_CODING, 32'h3);
		rdchk(dvp_pkg::ADDR_LINE, 32'h10, 32'h3FFF);
		$display("test line length done");
		ctlq.delete();
		wr(dvp_pkg::ADDR_MISC, 32'h6);
		repeat (20) @(posedge aclk);
		chk(32'(ctlq.size()), 32'h2);
		if (ctlq.size() == 2) begin
			chk({29'h0, ctlq[0].kind, ctlq[0].value},
				{29'h0, dvp_pkg::KIND_SHUTDOWN, 1'b1});
			chk({29'h0, ctlq[1].kind, ctlq[1].value},
				{29'h0, dvp_pkg::KIND_COLOR, 1'b1});
		end
		$display("test commands done");
		// two hsync rises reach line 2, the only active line
		repeat (2) begin
			host.beat(1'b1, 1'b1, 1'b0, P);
			host.beat(1'b1, 1'b0, 1'b0, P);
		end
		repeat (10) @(posedge aclk);
		chk({31'h0, in_active}, 32'h1);
		ctlq.delete();
		wr(dvp_pkg::ADDR_MISC, 32'h2);
		repeat (20) @(posedge aclk);
		chk(32'(ctlq.size()), 32'h0);
		host.beat(1'b1, 1'b1, 1'b0, P);
		repeat (20) @(posedge aclk);
		chk({31'h0, in_active}, 32'h0);
		chk(32'(ctlq.size()), 32'h3);
		if (ctlq.size() == 3)
			chk({29'h0, ctlq[2].kind, ctlq[2].value},
				{29'h0, dvp_pkg::KIND_COLOR, 1'b0});
		ctlq.delete();
		host.cmd_pins(1'b1, 1'b0);
		host.beat(1'b1, 1'b1, 1'b0, P);
		repeat (20) @(posedge aclk);
		chk(32'(ctlq.size()), 32'h1);
		if (ctlq.size() == 1)
			chk({29'h0, ctlq[0].kind, ctlq[0].value},
				{29'h0, dvp_pkg::KIND_SHUTDOWN, 1'b1});
		$display("test active region done");
		test_done();
	end
endmodule : dvp_pixel_input_tb_top
